// >>> rtl/tlic_ctrl.sv
// two-level twelve-source interrupt controller with avalon-mm registers
// Operation
// - twelve sources, two priority levels
// - per-source priority bits in two registers
// - equal or higher level in service blocks
// - high request preempts low handler
// - nested in-service kept per level
// - fixed polling order breaks level ties
// - cleared source enable never taken
// - global enable clear blocks all
// - pending flags readable by software
// - sample each cycle, evaluate next cycle
// - eligible flag issues call to vector
// - four conditions suppress the call
// - no memory of blocked samples
// - call pushes pc, no status save
// - return ends current level in service
// - edge external flag cleared on entry
// - level external flag kept on entry
// - serial request is rx or tx flag
//
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "tlic_regs.svh"
module tlic_ctrl #(
  parameter int NSRC = `TLIC_NSRC
) (
  input wire logic sys_clk_in,                  // core clock, 20 mhz
  input wire logic srst_in,                     // sync reset, high
  input wire logic [3:0] avs_address_in,        // word index
  input wire logic avs_read_in,                 // read strobe
  input wire logic avs_write_in,                // write strobe
  input wire logic [31:0] avs_writedata_in,     // write data
  input wire logic [3:0] avs_byteenable_in,     // byte lanes
  output logic [31:0] avs_readdata_out,         // read data
  output logic avs_waitrequest_out,             // stall
  input wire logic [NSRC-1:0] src_flag_in,      // peripheral flags
  input wire logic serial_rx_done_flag_in,      // uart0 rx
  input wire logic serial_tx_done_flag_in,      // uart0 tx
  input wire logic serial1_rx_done_flag_in,     // uart1 rx
  input wire logic serial1_tx_done_flag_in,     // uart1 tx
  input wire tlic_pkg::tlic_core_t core_in,     // sequencer status
  output tlic_pkg::tlic_call_t call_out,        // call request
  output logic [1:0] in_service_out             // [1] high, [0] low
);
  import tlic_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] source_enable_reg_a;
  logic [7:0] source_enable_reg_b;
  logic [7:0] priority_select_reg_a;
  logic [7:0] priority_select_reg_b;
  logic [1:0] ext_edge_mode;   // 1 = edge-triggered external input
  logic [1:0] ext_pend;        // ext_req0_pending, ext_req1_pending
  logic [1:0] in_service;
  logic [NSRC-1:0] sample;
  logic [NSRC-1:0] raw;
  logic [NSRC-1:0] ena;
  logic [NSRC-1:0] pri;
  logic global_irq_enable;
  logic bus_hit;
  logic ack;

  // source index map: 0 ext0, 1 t0, 2 ext1, 3 t1, 4 uart0, 5 t2, 6 spi,
  // 7 usb, 8 i2c, 9 adc, 10 pca, 11 uart1
  assign global_irq_enable = source_enable_reg_a[`TLIC_GEN_BIT];
  assign ena = {source_enable_reg_b[4], source_enable_reg_b[5],
    source_enable_reg_b[7], source_enable_reg_b[1],
    source_enable_reg_b[0], source_enable_reg_b[6],
    source_enable_reg_a[5:0]};
  assign pri = {priority_select_reg_b[4], priority_select_reg_b[5],
    priority_select_reg_b[7], priority_select_reg_b[1],
    priority_select_reg_b[0], priority_select_reg_b[6],
    priority_select_reg_a[5:0]};

  // serial sources are the or of their two done flags
  always_comb
  begin
    raw = src_flag_in;
    raw[0] = ext_pend[0];
    raw[2] = ext_pend[1];
    raw[4] = serial_rx_done_flag_in | serial_tx_done_flag_in;
    raw[11] = serial1_rx_done_flag_in | serial1_tx_done_flag_in;
  end

  // ****************************************
  // bus slave: one wait state per access
  // ****************************************
  assign bus_hit = (avs_read_in | avs_write_in) & avs_waitrequest_out;

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      avs_waitrequest_out <= 1'b1;
    else if (bus_hit & ~ack)
      avs_waitrequest_out <= 1'b0;
    else
      avs_waitrequest_out <= 1'b1;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      ack <= 1'b0;
    else
      ack <= bus_hit & ~ack;
  end

  logic wr_take;
  assign wr_take = avs_write_in & ~avs_waitrequest_out &
    avs_byteenable_in[0];

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      source_enable_reg_a <= `TLIC_RST_BYTE;
      source_enable_reg_b <= `TLIC_RST_BYTE;
      priority_select_reg_a <= `TLIC_RST_BYTE;
      priority_select_reg_b <= `TLIC_RST_BYTE;
      ext_edge_mode <= 2'h0;
    end
    else if (wr_take)
    begin
      unique case (avs_address_in)
        `TLIC_OFS_ENA: source_enable_reg_a <= avs_writedata_in[7:0];
        `TLIC_OFS_ENB: source_enable_reg_b <= avs_writedata_in[7:0];
        `TLIC_OFS_PRA: priority_select_reg_a <= avs_writedata_in[7:0];
        `TLIC_OFS_PRB: priority_select_reg_b <= avs_writedata_in[7:0];
        `TLIC_OFS_TRIG: ext_edge_mode <= avs_writedata_in[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      avs_readdata_out <= 32'h0;
    else if (bus_hit & ~ack & avs_read_in)
    begin
      unique case (avs_address_in)
        `TLIC_OFS_ENA: avs_readdata_out <= {24'h0, source_enable_reg_a};
        `TLIC_OFS_ENB: avs_readdata_out <= {24'h0, source_enable_reg_b};
        `TLIC_OFS_PRA: avs_readdata_out <= {24'h0, priority_select_reg_a};
        `TLIC_OFS_PRB: avs_readdata_out <= {24'h0, priority_select_reg_b};
        `TLIC_OFS_PEND: avs_readdata_out <= {20'h0, raw};
        `TLIC_OFS_STAT: avs_readdata_out <= {30'h0, in_service};
        `TLIC_OFS_TRIG: avs_readdata_out <= {30'h0, ext_edge_mode};
        default: avs_readdata_out <= 32'h0;
      endcase
    end
  end

  // ****************************************
  // sampling and polling
  // ****************************************
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      sample <= '0;
    else
      sample <= raw;
  end

  logic [NSRC-1:0] elig;
  logic [NSRC-1:0] elig_hi;
  logic [NSRC-1:0] pick_set;
  logic [3:0] pick;
  logic pick_hi;
  logic found;
  logic blocked;
  assign elig = sample & ena & {NSRC{global_irq_enable}};
  assign elig_hi = elig & pri;

  // lowest index wins within the chosen level
  always_comb
  begin
    pick = 4'h0;
    found = 1'b0;
    pick_hi = |elig_hi;
    pick_set = pick_hi ? elig_hi : elig;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (pick_set[i])
      begin
        pick = 4'(i);
        found = 1'b1;
      end
    end
  end

  always_comb
  begin
    blocked = in_service[1] | (in_service[0] & ~pick_hi);
    if (~core_in.final_cycle | core_in.ctl_write | core_in.is_return_from_handler_instr)
      blocked = 1'b1;
  end

  logic take;
  assign take = found & ~blocked & ~call_out.call;

  function automatic logic [15:0] vec_of(input logic [3:0] s);
    logic [15:0] v;
    v = `TLIC_VEC0;
    unique case (s)
      4'h1: v = `TLIC_VEC1;
      4'h2: v = `TLIC_VEC2;
      4'h3: v = `TLIC_VEC3;
      4'h4: v = `TLIC_VEC4;
      4'h5: v = `TLIC_VEC5;
      4'h6: v = `TLIC_VEC6;
      4'h7: v = `TLIC_VEC7;
      4'h8: v = `TLIC_VEC8;
      4'h9: v = `TLIC_VEC9;
      4'ha: v = `TLIC_VEC10;
      4'hb: v = `TLIC_VEC11;
      default: v = `TLIC_VEC0;
    endcase
    return v;
  endfunction : vec_of

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      call_out <= '0;
    else
    begin
      call_out.call <= take;
      call_out.push_pc <= take;
      if (take)
        call_out.vector <= vec_of(pick);
    end
  end

  // ****************************************
  // in-service tracking
  // ****************************************
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      in_service <= 2'h0;
    else if (take)
      in_service[pick_hi ? 1 : 0] <= 1'b1;
    else if (core_in.is_return_from_handler_instr & core_in.final_cycle)
    begin
      if (in_service[1])
        in_service[1] <= 1'b0;
      else
        in_service[0] <= 1'b0;
    end
  end
  assign in_service_out = in_service;

  // ****************************************
  // external request flags
  // ****************************************
  logic fclr_wr;
  assign fclr_wr = wr_take & (avs_address_in == `TLIC_OFS_FCLR);
  for (genvar e = 0; e < 2; e++)
  begin : g_ext
    always_ff @(posedge sys_clk_in)
    begin
      if (srst_in)
        ext_pend[e] <= 1'b0;
      else if (src_flag_in[2*e])
        ext_pend[e] <= 1'b1;     // set wins over clear
      else if (ext_edge_mode[e] & take & (pick == 4'(2*e)))
        ext_pend[e] <= 1'b0;
      else if (fclr_wr & avs_writedata_in[e])
        ext_pend[e] <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_call_pulse_one: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) call_out.call |=> ~call_out.call)
    else $error("call held two cycles");
  a_gate_blocks_all: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) ~global_irq_enable |=> ~call_out.call)
    else $error("call with global enable off");
  a_hi_blocks_hi: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) in_service[1] |=> ~call_out.call)
    else $error("call while high in service");
  a_suppress_return_from_handler_instr: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) core_in.is_return_from_handler_instr |=> ~call_out.call)
    else $error("call during return");
  a_preempt_sets: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) take & pick_hi |=> in_service == ($past(in_service) | 2'h2))
    else $error("high call did not nest");
  a_push_with_call: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) call_out.call |-> call_out.push_pc)
    else $error("call without push");
  a_return_from_handler_instr_clears: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) core_in.is_return_from_handler_instr & core_in.final_cycle & (in_service == 2'h3)
    |=> in_service == 2'h1)
    else $error("return did not unwind high");
  a_serial_or: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) serial_tx_done_flag_in |=> sample[4])
    else $error("serial tx not sampled");

  // reset must leave no handler running and no source armed
  a_reset_quiet: assert property (@(posedge sys_clk_in) srst_in |=>
    (in_service == 2'h0) && ~call_out.call &&
    (source_enable_reg_a == `TLIC_RST_BYTE))
    else $error("reset left state behind");

  // the sequencer may only be interrupted at an instruction boundary
  a_mid_cycle_hold: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) ~core_in.final_cycle |=> ~call_out.call)
    else $error("call before final cycle");
  a_ctl_wr_hold: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) core_in.ctl_write |=> ~call_out.call)
    else $error("call during control write");
  a_lo_blocks_lo: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) in_service[0] & ~|elig_hi |=> ~call_out.call)
    else $error("low call while low in service");
  a_src_enable: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) ~|(sample & ena) |=> ~call_out.call)
    else $error("call from disabled source");
  a_low_nests: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) take & ~pick_hi |=> in_service[0])
    else $error("low call not in service");
  a_prio_picks_hi: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) take & pick_hi |-> pri[pick])
    else $error("high level picked low source");

  // external flag handling on handler entry
  a_edge_clears: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) ext_edge_mode[0] & take & (pick == 4'h0) & ~src_flag_in[0]
    |=> ~ext_pend[0])
    else $error("edge flag kept on entry");
  a_level_keeps: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) ~ext_edge_mode[0] & ext_pend[0] & ~fclr_wr |=> ext_pend[0])
    else $error("level flag lost on entry");

  // return that ends the current handler
  sequence s_ret_done;
    core_in.is_return_from_handler_instr & core_in.final_cycle;
  endsequence

  a_return_from_handler_instr_low_clears: assert property (@(posedge sys_clk_in) disable iff
    (srst_in) s_ret_done ##0 (in_service == 2'h1) |=> in_service == 2'h0)
    else $error("return did not end low service");
endmodule : tlic_ctrl

// >>> rtl/tlic_pkg.sv
// types shared by the interrupt controller
package tlic_pkg;
  typedef struct packed {
    logic final_cycle;  // last machine cycle of current instruction
    logic ctl_write;    // instruction writes enable/priority regs
    logic is_return_from_handler_instr;      // return_from_handler_instr executing
  } tlic_core_t;
  typedef struct packed {
    logic call;         // long_subroutine_call request, one pulse
    logic [15:0] vector;
    logic push_pc;      // push pc only, status word not saved
  } tlic_call_t;
endpackage : tlic_pkg

// >>> rtl/tlic_regs.svh
// register offsets, field positions, reset values and vector constants
`ifndef TLIC_REGS_SVH
`define TLIC_REGS_SVH
// word offsets on the avalon bus (byte address = 4 * index)
`define TLIC_OFS_ENA 4'h0
`define TLIC_OFS_ENB 4'h1
`define TLIC_OFS_PRA 4'h2
`define TLIC_OFS_PRB 4'h3
`define TLIC_OFS_PEND 4'h4
`define TLIC_OFS_STAT 4'h5
`define TLIC_OFS_TRIG 4'h6
`define TLIC_OFS_FCLR 4'h7
// global enable position in source_enable_reg_a
`define TLIC_GEN_BIT 7
`define TLIC_RST_BYTE 8'h00
`define TLIC_NSRC 12
// vectors in polling order, source 0 first
`define TLIC_VEC0 16'h0003
`define TLIC_VEC1 16'h000b
`define TLIC_VEC2 16'h0013
`define TLIC_VEC3 16'h001b
`define TLIC_VEC4 16'h0023
`define TLIC_VEC5 16'h002b
`define TLIC_VEC6 16'h0053
`define TLIC_VEC7 16'h0033
`define TLIC_VEC8 16'h0043
`define TLIC_VEC9 16'h003b
`define TLIC_VEC10 16'h005b
`define TLIC_VEC11 16'h004b
`endif

// >>> test/tlic_core_model.sv
// core sequencer stand-in that drives the instruction status
`timescale 1ns/1ps
module tlic_core_model (
  input wire logic sys_clk_in,          // core clock
  input wire logic srst_in,             // sync reset, high
  input wire logic [1:0] mode_in,       // 0 run, 1 mid, 2 ctl, 3 ret
  input wire logic return_from_handler_instr_req_in,         // end the current handler
  output tlic_pkg::tlic_core_t core_out // sequencer status
);
  import tlic_pkg::*;
  logic return_from_handler_instr_q;
  // ****
  // handler return, one instruction long
  // ****
  always_ff @(posedge sys_clk_in)
  begin
    return_from_handler_instr_q <= return_from_handler_instr_req_in & ~srst_in;
  end
  // fields msb first: final_cycle, ctl_write, is_return_from_handler_instr
  assign core_out = {(mode_in != 2'h1), (mode_in == 2'h2),
    return_from_handler_instr_q | (mode_in == 2'h3)};
endmodule : tlic_core_model

// >>> test/tlic_ctrl_tb_top.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "tlic_regs.svh"
module tlic_ctrl_tb_top;
  import tlic_pkg::*;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic [3:0] be = 4'h1;
  logic [11:0] flg = 12'h000;
  logic [3:0] ser = 4'h0; // rx0, tx0, rx1, tx1
  logic [1:0] mode = 2'h0;
  logic return_from_handler_instr_req = 1'b0;
  tlic_core_t core;
  tlic_call_t call;
  logic [1:0] insvc;
  logic [31:0] rv;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  always #25 sys_clk_in = ~sys_clk_in;
  tlic_ctrl u_tlic_ctrl (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdat), .avs_byteenable_in(be),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .src_flag_in(flg), .serial_rx_done_flag_in(ser[0]),
    .serial_tx_done_flag_in(ser[1]), .serial1_rx_done_flag_in(ser[2]),
    .serial1_tx_done_flag_in(ser[3]), .core_in(core),
    .call_out(call), .in_service_out(insvc));
  tlic_core_model u_tlic_core_model (.sys_clk_in(sys_clk_in),
    .srst_in(srst_in), .mode_in(mode), .return_from_handler_instr_req_in(return_from_handler_instr_req),
    .core_out(core));
  // ****
  // tasks
  // ****
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    adr <= a;
    wdat <= {24'h0, d};
    wr <= w;
    rd <= ~w;
    do
      @(posedge sys_clk_in);
    while (wreq !== 1'b0);
    rv = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task take(input logic [15:0] v);
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (call.call !== 1'b1 && n < 30);
    chk({14'h0, call.call, call.push_pc, call.vector}, {16'h3, v});
  endtask : take
  task quiet(input int n);
    repeat (n)
    begin
      @(posedge sys_clk_in);
      chk({31'h0, call.call}, 32'h0);
    end
  endtask : quiet
  task ret;
    @(posedge sys_clk_in);
    return_from_handler_instr_req <= 1'b1;
    @(posedge sys_clk_in);
    return_from_handler_instr_req <= 1'b0;
  endtask : ret
  task svc(input logic [1:0] e);
    repeat (3) @(posedge sys_clk_in);
    chk({30'h0, insvc}, {30'h0, e});
  endtask : svc
  // ****
  // sequence
  // ****
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      complete_run;
    end
  end
  initial
  begin
    repeat (20) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      if (i != 7)
      begin
        bus(1'b0, 4'(i), 8'h00);
        chk(rv, 32'h0);
      end
    end
    bus(1'b1, 4'h8, 8'hff);
    bus(1'b0, 4'h8, 8'h00);
    chk(rv, 32'h0);
    be <= 4'h0;
    bus(1'b1, `TLIC_OFS_PRA, 8'h55);
    be <= 4'h1;
    bus(1'b0, `TLIC_OFS_PRA, 8'h00);
    chk(rv, 32'h0);
    bus(1'b1, `TLIC_OFS_PRA, 8'h08);
    bus(1'b0, `TLIC_OFS_PRA, 8'h00);
    chk(rv, 32'h8);
    bus(1'b1, `TLIC_OFS_ENA, 8'h3b);
    bus(1'b1, `TLIC_OFS_ENB, 8'h10);
    flg <= 12'h002;
    quiet(10);
    bus(1'b1, `TLIC_OFS_ENA, 8'hbb);
    take(`TLIC_VEC1);
    svc(2'h1);
    quiet(6);
    flg <= 12'h008;
    take(`TLIC_VEC3);
    flg <= 12'h000;
    svc(2'h3);
    ret;
    svc(2'h1);
    ret;
    svc(2'h0);
    flg <= 12'h022;
    take(`TLIC_VEC1);
    flg <= 12'h020;
    ret;
    take(`TLIC_VEC5);
    flg <= 12'h000;
    ret;
    for (int m = 1; m < 4; m++)
    begin
      @(posedge sys_clk_in);
      mode <= 2'(m);
      flg <= 12'h002;
      quiet(8);
      flg <= 12'h000;
      quiet(3);
      mode <= 2'h0;
      quiet(8);
    end
    flg <= 12'h004;
    quiet(10);
    bus(1'b0, `TLIC_OFS_PEND, 8'h00);
    chk(rv, 32'h4);
    flg <= 12'h000;
    // each of the four done flags alone raises its serial request
    for (int s = 0; s < 4; s++)
    begin
      ser <= 4'h1 << s;
      take((s < 2) ? `TLIC_VEC4 : `TLIC_VEC11);
      ser <= 4'h0;
      ret;
    end
    svc(2'h0);
    // edge mode: entry clears the flag
    bus(1'b1, `TLIC_OFS_TRIG, 8'h01);
    flg <= 12'h001;
    @(posedge sys_clk_in);
    flg <= 12'h000;
    take(`TLIC_VEC0);
    ret;
    quiet(10);
    // level mode: flag survives until firmware clears it
    bus(1'b1, `TLIC_OFS_TRIG, 8'h00);
    flg <= 12'h001;
    @(posedge sys_clk_in);
    flg <= 12'h000;
    take(`TLIC_VEC0);
    ret;
    take(`TLIC_VEC0);
    bus(1'b1, `TLIC_OFS_FCLR, 8'h01);
    ret;
    quiet(10);
    svc(2'h0);
    complete_run;
  end
endmodule : tlic_ctrl_tb_top
